//--- rtl/perf_qual_pkg.sv
package perf_qual_pkg;
  // coherent request/response qualifier
  localparam int unsigned CR_INVALID = 19;
  localparam int unsigned CR_SPEC = 18;
  localparam int unsigned CR_NO_SPEC = 17;
  localparam int unsigned CR_RSVD_HI = 16;
  localparam int unsigned CR_RSVD_LO = 15;
  localparam int unsigned CR_UPG_OK = 10;
  localparam int unsigned CR_UPG_DATA = 9;
  localparam int unsigned CR_SC_NONE = 2;
  localparam int unsigned CR_SC_KEPT = 1;
  localparam int unsigned CR_SC_CANCEL = 0;
  localparam int unsigned CR_CMD_LO = 3;
  localparam int unsigned CR_CMD_HI = 14;
  localparam int unsigned CR_INTV_LO = 19;
  localparam int unsigned CR_INTV_HI = 24;
  // accept state
  localparam int unsigned AS_COUNT_STALLS = 0;
  // data source
  localparam int unsigned DS_REQ_LO = 7;
  localparam int unsigned DS_RESP_LO = 1;
  localparam int unsigned DS_L2 = 0;
  // port response
  localparam int unsigned PR_READ = 5;
  localparam int unsigned PR_WACK = 4;
  localparam int unsigned PR_OK = 3;
  localparam int unsigned PR_PORT_LO = 0;
  // l2 utilisation
  localparam int unsigned LU_START_STALL = 5;
  localparam int unsigned LU_START_TAKEN = 4;
  localparam int unsigned LU_SYNC_WAIT = 3;
  localparam int unsigned LU_NEW_STALL = 2;
  localparam int unsigned LU_NEW_DENIED = 1;
  localparam int unsigned LU_NEW_START = 0;
  // l2 hit
  localparam int unsigned HT_MERGED = 21;
  localparam int unsigned HT_NOT_MERGED = 20;
  localparam int unsigned HT_ALLOC = 19;
  localparam int unsigned HT_NO_ALLOC = 18;
  localparam int unsigned HT_TYPE_LO = 8;
  localparam int unsigned HT_OTHER = 17;
  localparam int unsigned HT_CO_HIT = 16;
  localparam int unsigned HT_CO_MISS = 15;
  localparam int unsigned HT_WR_HIT = 14;
  localparam int unsigned HT_WR_HIT_RMW = 13;
  localparam int unsigned HT_WR_MISS = 12;
  localparam int unsigned HT_WR_MISS_RD = 11;
  localparam int unsigned HT_RD_PEND = 10;
  localparam int unsigned HT_RD_HIT = 9;
  localparam int unsigned HT_RD_MISS = 8;
  localparam int unsigned HT_PORT_LO = 0;
  // i/o unit request
  localparam int unsigned IO_TAG_LO = 27;
  localparam int unsigned IO_ANY_TAG = 26;
  localparam int unsigned IO_TXN_LO = 18;
  localparam int unsigned IO_BURST_LO = 9;
  localparam int unsigned IO_ALLOC = 8;
  localparam int unsigned IO_NO_ALLOC = 7;
  localparam int unsigned IO_NONPOSTED = 6;
  localparam int unsigned IO_POSTED = 5;
  localparam int unsigned IO_UNCACHED = 4;
  localparam int unsigned IO_CACHED = 3;
  localparam int unsigned IO_COHERENT = 2;
  localparam int unsigned IO_READ = 1;
  localparam int unsigned IO_WRITE = 0;
  // register map (byte offsets)
  localparam logic [7:0] REG_EVENT = 8'h00;
  localparam logic [7:0] REG_QUAL = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [31:0] EVENT_RST = 32'h0000_0000;
  localparam logic [31:0] QUAL_RST = 32'h0000_0000;
  // event selects
  localparam logic [4:0] EV_COH_REQ = 5'h01;
  localparam logic [4:0] EV_L2_WR_UTIL = 5'h02;
  localparam logic [4:0] EV_L2_COMMAND_BUS_UTILISATION = 5'h03;
  localparam logic [4:0] EV_SHARING = 5'h05;
  localparam logic [4:0] EV_RESP_UTIL = 5'h06;
  localparam logic [4:0] EV_L2_UTIL = 5'h08;
  localparam logic [4:0] EV_L2_HIT = 5'h09;
  localparam logic [4:0] EV_IO_REQ = 5'h10;
  // coherent command codes on the attribute port
  localparam logic [3:0] CMD_READ_SHARED = 4'h0;
  localparam logic [3:0] CMD_READ_SHARED_FORCED = 4'h1;
  localparam logic [3:0] CMD_READ_EXCLUSIVE = 4'h2;
  localparam logic [3:0] CMD_READ_NO_KEEP = 4'h3;
  localparam logic [3:0] CMD_LINE_UPGRADE = 4'h4;
  localparam logic [3:0] CMD_LINE_EVICT = 4'h5;
  localparam logic [3:0] CMD_WRITE_INV_PART = 4'h6;
  localparam logic [3:0] CMD_WRITE_INV_FULL = 4'h7;
  localparam logic [3:0] CMD_LINE_INVALIDATE = 4'h8;
  localparam logic [3:0] CMD_HIT_WRITEBACK = 4'h9;
  localparam logic [3:0] CMD_HIT_WRITEBACK_INV = 4'ha;
  localparam logic [3:0] CMD_READ_FORCED = 4'hb;
  // l2 hit type codes
  typedef enum logic [3:0] {
    HIT_OTHER = 4'h0, HIT_CO_HIT = 4'h1, HIT_CO_MISS = 4'h2, HIT_WRITE = 4'h3,
    HIT_WR_MISS = 4'h4, HIT_WR_MISS_RD = 4'h5, HIT_RD_PEND = 4'h6,
    HIT_RD_HIT = 4'h7, HIT_RD_MISS = 4'h8
  } hit_type_e;
  // counter control state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } cnt_state_e;
endpackage : perf_qual_pkg

//--- rtl/coherence_perf_event_qualifiers.sv
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module coherence_perf_event_qualifiers (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // coherent request/response attributes
  input wire logic coh_valid,
  input wire logic [3:0] coh_cmd,
  input wire logic [5:0] coh_intervention,
  input wire logic coh_speculated,
  input wire logic coh_upgrade_data,
  input wire logic coh_store_cond,
  input wire logic coh_sc_cancelled,
  // l2 write data and command buses
  input wire logic l2_wdata_valid,
  input wire logic l2_wdata_accept,
  input wire logic l2_cmd_valid,
  input wire logic l2_cmd_accept,
  // data source
  input wire logic ds_valid,
  input wire logic [2:0] ds_req_port,
  input wire logic ds_from_l2,
  input wire logic [2:0] ds_resp_port,
  // response bus, one doubleword per valid
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_port,
  input wire logic rsp_read_data,
  input wire logic rsp_write_ack,
  input wire logic rsp_ok,
  // l2 pipeline
  input wire logic [5:0] l2_pipe_events,
  // l2 hit/miss
  input wire logic hit_valid,
  input wire logic [3:0] hit_type,
  input wire logic [2:0] hit_port,
  input wire logic hit_partial,
  input wire logic hit_merged,
  input wire logic hit_allocated,
  input wire logic [7:0] hit_byte_en_ok,
  // i/o unit request sideband
  input wire logic io_valid,
  input wire logic [3:0] io_tag,
  input wire logic [7:0] io_txn_count,
  input wire logic [8:0] io_burst_qw,
  input wire logic io_alloc,
  input wire logic io_posted,
  input wire logic [1:0] io_cache,
  input wire logic io_read,
  output logic count_event
);

  logic [31:0] event_q;
  logic [31:0] qual_q;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic enable_q;
  logic aw_seen_q;
  logic w_seen_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [1:0] bresp_q;
  logic count_q1;
  perf_qual_pkg::cnt_state_e state_q;

  // bucket index of a count: 1,2,3-4,5-8,... -> 0,1,2,3,...
  function automatic logic [3:0] bucket(input logic [8:0] n);
    logic [3:0] b;
    b = 4'h0;
    for (int i = 0; i < 9; i++) begin
      if ((n - 9'h001) >> i != 9'h000) begin
        b = 4'(i + 1);
      end
    end
    return b;
  endfunction : bucket

  wire [4:0] ev = event_q[4:0];
  wire [31:0] q = qual_q;

  // coherent request/response
  // the forced-shared read is not one of the speculating reads, the unused forced read is
  wire is_coh_read = coh_cmd == perf_qual_pkg::CMD_READ_SHARED
    || coh_cmd == perf_qual_pkg::CMD_READ_EXCLUSIVE || coh_cmd == perf_qual_pkg::CMD_READ_NO_KEEP
    || coh_cmd == perf_qual_pkg::CMD_READ_FORCED;
  wire is_upg = coh_cmd == perf_qual_pkg::CMD_LINE_UPGRADE;
  wire is_sc_cmd = is_upg || coh_cmd == perf_qual_pkg::CMD_READ_EXCLUSIVE;
  // coh_intervention[0] flags "no processor held the line"
  wire intv_ok = |(q[perf_qual_pkg::CR_INTV_HI:perf_qual_pkg::CR_INTV_LO]
    & {coh_intervention[5:1], coh_intervention[0]});
  wire spec_ok = !is_coh_read
    || (coh_speculated ? q[perf_qual_pkg::CR_SPEC] : q[perf_qual_pkg::CR_NO_SPEC]);
  logic [15:0] cmd_hot;
  always_comb begin
    cmd_hot = 16'h0000;
    unique case (coh_cmd)
      perf_qual_pkg::CMD_READ_SHARED: cmd_hot[14] = 1'b1;
      perf_qual_pkg::CMD_READ_SHARED_FORCED: cmd_hot[13] = 1'b1;
      perf_qual_pkg::CMD_READ_EXCLUSIVE: cmd_hot[12] = 1'b1;
      perf_qual_pkg::CMD_READ_NO_KEEP: cmd_hot[11] = 1'b1;
      perf_qual_pkg::CMD_LINE_UPGRADE: cmd_hot[coh_upgrade_data ? 9 : 10] = 1'b1;
      perf_qual_pkg::CMD_LINE_EVICT: cmd_hot[8] = 1'b1;
      perf_qual_pkg::CMD_WRITE_INV_PART: cmd_hot[7] = 1'b1;
      perf_qual_pkg::CMD_WRITE_INV_FULL: cmd_hot[6] = 1'b1;
      perf_qual_pkg::CMD_LINE_INVALIDATE: cmd_hot[5] = 1'b1;
      perf_qual_pkg::CMD_HIT_WRITEBACK: cmd_hot[4] = 1'b1;
      perf_qual_pkg::CMD_HIT_WRITEBACK_INV: cmd_hot[3] = 1'b1;
      default: cmd_hot = 16'h0000;
    endcase
  end
  // reserved bits 16:15 never enter the command match
  wire cmd_ok = |(q[perf_qual_pkg::CR_CMD_HI:perf_qual_pkg::CR_CMD_LO]
    & cmd_hot[14:3]);
  wire sc_ok = !is_sc_cmd || (!coh_store_cond ? q[perf_qual_pkg::CR_SC_NONE]
    : coh_sc_cancelled ? q[perf_qual_pkg::CR_SC_CANCEL] : q[perf_qual_pkg::CR_SC_KEPT]);
  wire coh_hit = coh_valid && intv_ok && spec_ok && cmd_ok && sc_ok;

  // accept state
  wire stalls = q[perf_qual_pkg::AS_COUNT_STALLS];
  wire wr_util_hit = stalls ? l2_wdata_valid : l2_wdata_valid && l2_wdata_accept;
  wire cmd_util_hit = stalls ? l2_cmd_valid : l2_cmd_valid && l2_cmd_accept;

  // data source
  wire ds_req_ok = q[perf_qual_pkg::DS_REQ_LO + 32'(ds_req_port)];
  wire ds_src_ok = ds_from_l2 ? q[perf_qual_pkg::DS_L2]
    : (ds_resp_port < 3'h6) && q[perf_qual_pkg::DS_RESP_LO + 32'(ds_resp_port)];
  wire ds_hit = ds_valid && ds_req_ok && ds_src_ok;

  // port response
  wire rsp_type_ok = (q[perf_qual_pkg::PR_READ] && rsp_read_data)
    || (q[perf_qual_pkg::PR_WACK] && rsp_write_ack) || (q[perf_qual_pkg::PR_OK] && rsp_ok);
  wire rsp_port_ok = rsp_port == q[perf_qual_pkg::PR_PORT_LO +: 3];
  // one port per counter, each valid is one doubleword
  wire rsp_hit = rsp_valid && rsp_type_ok && rsp_port_ok;

  // l2 pipeline: events [5] start stalled [4] start taken [3] sync wait
  // [2] new stalled [1] new denied [0] new started
  wire lu_hit = |(q[perf_qual_pkg::LU_START_STALL:perf_qual_pkg::LU_NEW_START]
    & l2_pipe_events);

  // l2 hit/miss: one-hot class from a single type code
  logic [9:0] type_hot;
  always_comb begin
    type_hot = 10'h000;
    unique case (hit_type)
      perf_qual_pkg::HIT_OTHER: type_hot[9] = 1'b1;
      perf_qual_pkg::HIT_CO_HIT: type_hot[8] = 1'b1;
      perf_qual_pkg::HIT_CO_MISS: type_hot[7] = 1'b1;
      perf_qual_pkg::HIT_WRITE: type_hot[(&hit_byte_en_ok) ? 6 : 5] = 1'b1;
      perf_qual_pkg::HIT_WR_MISS: type_hot[4] = 1'b1;
      perf_qual_pkg::HIT_WR_MISS_RD: type_hot[3] = 1'b1;
      perf_qual_pkg::HIT_RD_PEND: type_hot[2] = 1'b1;
      perf_qual_pkg::HIT_RD_HIT: type_hot[1] = 1'b1;
      perf_qual_pkg::HIT_RD_MISS: type_hot[0] = 1'b1;
      default: type_hot = 10'h000;
    endcase
  end
  wire type_ok = |(q[perf_qual_pkg::HT_OTHER:perf_qual_pkg::HT_TYPE_LO] & type_hot);
  wire is_wr_miss = type_hot[4] | type_hot[3];
  wire is_miss = is_wr_miss | type_hot[0];
  wire merge_ok = !(is_wr_miss && hit_partial) || (hit_merged ? q[perf_qual_pkg::HT_MERGED]
    : q[perf_qual_pkg::HT_NOT_MERGED]);
  wire alloc_ok = !is_miss || (hit_allocated ? q[perf_qual_pkg::HT_ALLOC]
    : q[perf_qual_pkg::HT_NO_ALLOC]);
  wire hport_ok = q[perf_qual_pkg::HT_PORT_LO + 32'(hit_port)];
  wire l2hit_hit = hit_valid && type_ok && merge_ok && alloc_ok && hport_ok;

  // i/o unit request
  wire tag_ok = q[perf_qual_pkg::IO_ANY_TAG]
    || io_tag == q[perf_qual_pkg::IO_TAG_LO +: 4];
  // 129 sits one past a power of two but belongs to the widest bucket
  wire [3:0] txn_raw = bucket({1'b0, io_txn_count});
  wire [3:0] txn_b = io_txn_count == 8'h81 ? 4'h7 : txn_raw;
  wire txn_ok = io_txn_count != 8'h00 && txn_b < 4'h8
    && q[perf_qual_pkg::IO_TXN_LO + 32'(txn_b)];
  wire [3:0] bl_b = bucket(io_burst_qw);
  wire bl_ok = io_burst_qw != 9'h000 && bl_b < 4'h9
    && q[perf_qual_pkg::IO_BURST_LO + 32'(bl_b)];
  wire alloc_io_ok = io_alloc ? q[perf_qual_pkg::IO_ALLOC] : q[perf_qual_pkg::IO_NO_ALLOC];
  wire posted_ok = io_read || (io_posted ? q[perf_qual_pkg::IO_POSTED]
    : q[perf_qual_pkg::IO_NONPOSTED]);
  // io_cache: 0 uncached, 1 cached non-coherent, 2 coherent
  wire cache_ok = (io_cache == 2'h0 && q[perf_qual_pkg::IO_UNCACHED])
    || (io_cache == 2'h1 && q[perf_qual_pkg::IO_CACHED])
    || (io_cache == 2'h2 && q[perf_qual_pkg::IO_COHERENT]);
  wire dir_ok = io_read ? q[perf_qual_pkg::IO_READ] : q[perf_qual_pkg::IO_WRITE];
  wire io_hit = io_valid && tag_ok && txn_ok && bl_ok && alloc_io_ok
    && posted_ok && cache_ok && dir_ok;

  logic sel_hit;
  always_comb begin
    unique case (ev)
      perf_qual_pkg::EV_COH_REQ: sel_hit = coh_hit;
      perf_qual_pkg::EV_L2_WR_UTIL: sel_hit = wr_util_hit;
      perf_qual_pkg::EV_L2_COMMAND_BUS_UTILISATION: sel_hit = cmd_util_hit;
      perf_qual_pkg::EV_SHARING: sel_hit = ds_hit;
      perf_qual_pkg::EV_RESP_UTIL: sel_hit = rsp_hit;
      perf_qual_pkg::EV_L2_UTIL: sel_hit = lu_hit;
      perf_qual_pkg::EV_L2_HIT: sel_hit = l2hit_hit;
      perf_qual_pkg::EV_IO_REQ: sel_hit = io_hit;
      default: sel_hit = 1'b0;
    endcase
  end
  wire counting = state_q == perf_qual_pkg::ST_RUN;
  assign count_d = count_q + 32'(counting && sel_hit);

  // axi4-lite slave; write address and data taken in either order
  assign s_axi_awready = !aw_seen_q && !bvalid_q;
  assign s_axi_wready = !w_seen_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  wire aw_now = aw_seen_q || (s_axi_awvalid && s_axi_awready);
  wire w_now = w_seen_q || (s_axi_wvalid && s_axi_wready);
  wire wr_go = aw_now && w_now && !bvalid_q;
  wire [7:0] wa = aw_seen_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_seen_q ? wdata_q : s_axi_wdata;
  wire wa_ok = wa == perf_qual_pkg::REG_EVENT || wa == perf_qual_pkg::REG_QUAL
    || wa == perf_qual_pkg::REG_COUNT || wa == perf_qual_pkg::REG_CTRL;
  wire [3:0] wstrb_eff = s_axi_wstrb;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  // strobes latched alongside data cost a register; strobes must stay with wdata
  logic [3:0] wstrb_q;
  wire [3:0] ws = w_seen_q ? wstrb_q : wstrb_eff;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      perf_qual_pkg::REG_EVENT: rd_val = event_q;
      perf_qual_pkg::REG_QUAL: rd_val = qual_q;
      perf_qual_pkg::REG_COUNT: rd_val = count_q;
      perf_qual_pkg::REG_CTRL: rd_val = {31'h0000_0000, enable_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end
  wire rd_ok = s_axi_araddr == perf_qual_pkg::REG_EVENT || s_axi_araddr == perf_qual_pkg::REG_QUAL
    || s_axi_araddr == perf_qual_pkg::REG_COUNT || s_axi_araddr == perf_qual_pkg::REG_CTRL;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_seen_q <= 1'b0;
      w_seen_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      aw_seen_q <= wr_go ? 1'b0 : aw_now;
      w_seen_q <= wr_go ? 1'b0 : w_now;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wa_ok ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? 2'h0 : 2'h3;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  wire wr_ev = wr_go && wa == perf_qual_pkg::REG_EVENT;
  wire wr_ql = wr_go && wa == perf_qual_pkg::REG_QUAL;
  wire wr_ct = wr_go && wa == perf_qual_pkg::REG_COUNT;
  wire wr_cl = wr_go && wa == perf_qual_pkg::REG_CTRL && ws[0];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_q <= perf_qual_pkg::EVENT_RST;
      qual_q <= perf_qual_pkg::QUAL_RST;
      enable_q <= 1'b0;
      state_q <= perf_qual_pkg::ST_IDLE;
      count_q <= 32'h0000_0000;
      count_q1 <= 1'b0;
    end else begin
      event_q <= wr_ev ? merge(event_q, wd, ws) : event_q;
      qual_q <= wr_ql ? merge(qual_q, wd, ws) : qual_q;
      enable_q <= wr_cl ? wd[0] : enable_q;
      state_q <= enable_q ? perf_qual_pkg::ST_RUN : perf_qual_pkg::ST_IDLE;
      // a software write to the count wins over a same-cycle increment
      count_q <= wr_ct ? merge(count_q, wd, ws) : count_d;
      count_q1 <= counting && sel_hit;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign count_event = count_q1;
endmodule : coherence_perf_event_qualifiers
`default_nettype wire

//--- tb/coherence_perf_event_qualifiers_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module coherence_perf_event_qualifiers_check (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic coh_valid,
  input wire logic l2_wdata_valid,
  input wire logic l2_cmd_valid,
  input wire logic ds_valid,
  input wire logic rsp_valid,
  input wire logic [5:0] l2_pipe_events,
  input wire logic hit_valid,
  input wire logic io_valid,
  input wire logic count_event
);
  logic any_occ;
  // a count needs some occurrence a cycle earlier, whatever the qualifier
  assign any_occ = coh_valid | l2_wdata_valid | l2_cmd_valid | ds_valid | rsp_valid
    | (|l2_pipe_events) | hit_valid | io_valid;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (write_taken |=> s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (read_taken |=> s_axi_rvalid)
    else $error("read response missing");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while response pending");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h3)
    else $error("bad write response code");
  event_cause_a: assert property (count_event |-> $past(any_occ))
    else $error("count without occurrence");
  reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> !count_event && !s_axi_bvalid)
    else $error("outputs active after reset");
  counted_c: cover property (count_event);
endmodule : coherence_perf_event_qualifiers_check
bind coherence_perf_event_qualifiers coherence_perf_event_qualifiers_check u_check (.clock,
  .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .coh_valid, .l2_wdata_valid, .l2_cmd_valid, .ds_valid,
  .rsp_valid, .l2_pipe_events, .hit_valid, .io_valid, .count_event);
`default_nettype wire

//--- tb/coherence_perf_event_qualifiers_bench.sv
`timescale 1ns/100ps
`default_nettype none
module coherence_perf_event_qualifiers_bench;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, fire, ex;
  logic awready, wready, bvalid, arready, rvalid, count_event;
  logic [1:0] bresp, rresp, br, rr;
  logic [2:0] dsp, tt;
  logic [3:0] cmd, ht, qt;
  logic [7:0] awaddr, araddr, v, txn;
  logic [8:0] brst;
  logic [31:0] wdata, rdata, rd, q;
  logic [63:0] at;
  int seed, bad_count, checked, cyc, tb, rb;
  coherence_perf_event_qualifiers u_dut (.clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .coh_valid(fire & v[0]), .coh_cmd(cmd), .coh_intervention(at[5:0]),
    .coh_speculated(at[9]), .coh_upgrade_data(at[6]), .coh_store_cond(at[7]),
    .coh_sc_cancelled(at[8]), .l2_wdata_valid(fire & v[1]), .l2_wdata_accept(at[48]),
    .l2_cmd_valid(fire & v[2]), .l2_cmd_accept(at[49]), .ds_valid(fire & v[3]),
    .ds_req_port(at[12:10]), .ds_from_l2(at[13]), .ds_resp_port(dsp),
    .rsp_valid(fire & v[4]), .rsp_port(at[16:14]), .rsp_read_data(at[17]),
    .rsp_write_ack(at[18]), .rsp_ok(at[19]), .l2_pipe_events(fire & v[5] ? at[25:20] : 6'h00),
    .hit_valid(fire & v[6]), .hit_type(ht), .hit_port(at[28:26]), .hit_partial(at[29]),
    .hit_merged(at[30]), .hit_allocated(at[31]), .hit_byte_en_ok(at[39:32]),
    .io_valid(fire & v[7]), .io_tag(at[43:40]), .io_txn_count(txn), .io_burst_qw(brst),
    .io_alloc(at[44]), .io_posted(at[45]), .io_cache(at[55:54] == 2'h3 ? 2'h2 : at[55:54]),
    .io_read(at[47]),
    .count_event(count_event));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic int r(input int n);
    return ($random(seed) & 32'h7fffffff) % n;
  endfunction : r
  function automatic int lg(input int n);
    int k;
    k = 0;
    while ((1 << k) < n) k++;
    // the widest transaction bucket also takes 129
    return (k > 7) ? 7 : k;
  endfunction : lg
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br = bresp; bready <= 1'b0;
  endtask : axw
  task axr(input logic [7:0] a);
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata; rr = rresp; rready <= 1'b0;
  endtask : axr
  // attributes re-rolled each trial so ignored groups see random values
  task rnd;
    @(posedge clock);
    at <= {$random(seed), $random(seed)}; cmd <= 4'(r(12)); dsp <= 3'(r(6));
    ht <= 4'(6 + r(3)); txn <= 8'(1 + r(129)); brst <= 9'(1 + r(256));
    @(posedge clock);
  endtask : rnd
  // one occurrence per trial, so the count reads back as 0 or 1
  task trial(input logic [4:0] ev, input logic [31:0] qv, input logic e);
    axw(perf_qual_pkg::REG_EVENT, {27'h0, ev});
    axw(perf_qual_pkg::REG_QUAL, qv);
    axw(perf_qual_pkg::REG_COUNT, 32'h0);
    @(posedge clock); fire <= 1'b1;
    @(posedge clock); fire <= 1'b0;
    @(posedge clock);
    chk("count_event", {31'h0, e}, {31'h0, count_event});
    axr(perf_qual_pkg::REG_COUNT);
    chk("count", {31'h0, e}, rd);
  endtask : trial
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    seed = 37; rst_n = 1'b0; fire = 1'b0; at = '0; v = 8'h00; cmd = 4'h0; dsp = 3'h0; ht = 4'h6;
    txn = 8'h1; brst = 9'h1; awaddr = 8'h0; wdata = '0; araddr = 8'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    axr(perf_qual_pkg::REG_EVENT); chk("event", perf_qual_pkg::EVENT_RST, rd);
    axr(perf_qual_pkg::REG_QUAL); chk("qual", perf_qual_pkg::QUAL_RST, rd);
    axr(8'h40); chk("rresp", 32'h3, {30'h0, rr}); chk("rdata", 32'h0, rd);
    axw(8'h44, 32'h1); chk("bresp", 32'h3, {30'h0, br});
    axw(perf_qual_pkg::REG_CTRL, 32'h1);
    $display("test registers done");
    v <= 8'h01;
    repeat (12) begin
      rnd();
      q = 32'h01f879f8 | (32'(r(4)) << 17) | (32'(r(4)) << 15)
        | {21'h0, at[57:56], 6'h0, at[60:58]};
      ex = (|at[5:0]) && cmd != 4'hb && (cmd == 4'h1 || cmd > 4'h3 || (at[9] ? q[18] : q[17]))
        && (cmd != 4'h4 || (at[6] ? q[9] : q[10]))
        && ((cmd != 4'h2 && cmd != 4'h4) || (!at[7] ? q[2] : at[8] ? q[0] : q[1]));
      trial(perf_qual_pkg::EV_COH_REQ, q, ex);
    end
    $display("test coherent done");
    repeat (8) begin
      rnd();
      tb = r(2); q = 32'(r(2)); v <= tb ? 8'h04 : 8'h02;
      ex = q[0] | (tb ? at[49] : at[48]);
      trial(tb ? perf_qual_pkg::EV_L2_COMMAND_BUS_UTILISATION : perf_qual_pkg::EV_L2_WR_UTIL, q, ex);
    end
    $display("test accept done");
    v <= 8'h08;
    repeat (10) begin
      rnd();
      q = 32'(r(32768));
      ex = q[7 + at[12:10]] && (at[13] ? q[0] : q[1 + dsp]);
      trial(perf_qual_pkg::EV_SHARING, q, ex);
    end
    v <= 8'h10;
    repeat (10) begin
      rnd();
      tt = 3'(r(8)); q = {26'h0, tt, at[52] ? at[16:14] : 3'(r(8))};
      ex = (|(tt & {at[17], at[18], at[19]})) && q[2:0] == at[16:14];
      trial(perf_qual_pkg::EV_RESP_UTIL, q, ex);
    end
    v <= 8'h20;
    repeat (8) begin
      rnd();
      q = 32'(r(64));
      trial(perf_qual_pkg::EV_L2_UTIL, q, |(q[5:0] & at[25:20]));
    end
    v <= 8'h40;
    repeat (8) begin
      rnd();
      tb = 8 + r(3); q = 32'h003c00ff | (32'h1 << tb);
      trial(perf_qual_pkg::EV_L2_HIT, q, tb == 16 - ht);
    end
    $display("test pipeline and hit done");
    v <= 8'h80;
    repeat (12) begin
      rnd();
      rb = at[51] ? lg(txn) : r(8); qt = at[50] ? at[43:40] : 4'(r(16));
      q = {1'b0, qt, at[53], 8'(1 << rb), 13'h1fff, at[58:56], 2'h3};
      ex = (at[53] || qt == at[43:40]) && rb == lg(txn)
        && at[58 - ((at[55:54] == 2'h3) ? 2 : at[55:54])];
      trial(perf_qual_pkg::EV_IO_REQ, q, ex);
    end
    $display("test io done");
    results();
  end
endmodule : coherence_perf_event_qualifiers_bench
`default_nettype wire
